// *** shared/aecf_pkg.sv ***
`default_nettype none
package aecf_pkg;
  // register map (word index times four gives byte address)
  localparam logic [7:0] ADDR_CAUSE = 8'h00;
  localparam logic [7:0] ADDR_CTRL = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
  localparam logic [7:0] ADDR_IRQ_CLR = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h10;
  // cause word field positions
  localparam int BIT_CMP1 = 0;
  localparam int BIT_CMP2 = 1;
  localparam int BIT_CMP3 = 2;
  localparam int BIT_PEL = 3;
  localparam int BIT_NEL = 4;
  localparam int BIT_ALM = 5;
  localparam int BIT_STOP = 6;
  localparam int BIT_EMG = 7;
  localparam int BIT_SLOW = 8;
  localparam int BIT_POVF = 9;
  localparam int BIT_WDOG = 10;
  localparam int CAUSE_W = 11;
  // control register field
  localparam int BIT_RCI = 0;
  // reset values
  localparam logic [CAUSE_W-1:0] CAUSE_RST = 11'h000;
  localparam logic CTRL_RCI_RST = 1'b0;
  localparam logic [CAUSE_W-1:0] IRQ_STAT_RST = 11'h000;
  localparam logic [CAUSE_W-1:0] IRQ_EN_RST = 11'h000;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;
  // register bus request carrier
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } aecf_bus_req_t;
  // stop and error event carrier, one bit per cause
  typedef struct packed {
    logic wdog_stop;
    logic pulser_ovf;
    logic slowdown;
    logic emergency;
    logic ext_stop;
    logic alarm;
    logic neg_limit;
    logic pos_limit;
    logic cmp3;
    logic cmp2;
    logic cmp1;
  } aecf_events_t;
endpackage
`default_nettype wire

// *** rtl/aecf_cause_flags.sv ***
// Function
// - Bit 0 is set when the axis stops on the comparator 1 match (positive software limit).
// - Bit 1 is set when the axis stops on the comparator 2 match (negative software limit).
// - Bit 2 is set when the axis stops on the comparator 3 match.
// - Bit 3 is set when motion halts because the positive end-limit input turns on.
// - Bit 4 is set when motion halts because the negative end-limit input turns on.
// - Bit 5 is set when motion halts because the servo alarm input turns on.
// - Bit 6 is set when motion halts because the external stop input turns on.
// - Bit 7 is set when motion halts because the emergency input turns on.
// - Bit 8 is set when the axis decelerates to a stop because the slow-down input turns on.
// - Bit 9 is set when the manual pulser phase A/B buffer counter overflows.
// - Bit 10 is set when the axis stops on the communication watchdog after a link error.
// - With read-clear inhibit at 0, reading the cause word clears all its bits except any raised by an event in the same cycle.
// - Writing the cause word clears the bits written as 1 unless an event raises them in the same cycle, so writing back a read value clears what was seen.
`timescale 1ns/1ps
`default_nettype none
module aecf_cause_flags (
  // clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // register port
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  // stop events from the axis logic, same clock, one bit per cause
  input wire logic cmp1_stop_in,
  input wire logic cmp2_stop_in,
  input wire logic cmp3_stop_in,
  input wire logic pos_end_limit_stop_in,
  input wire logic neg_end_limit_stop_in,
  input wire logic servo_alarm_stop_in,
  input wire logic external_stop_in,
  input wire logic emergency_stop_in,
  input wire logic slowdown_stop_in,
  input wire logic pulser_overflow_in,
  input wire logic comm_watchdog_stop_in,
  // status and interrupt
  output logic axis_error_out,
  output logic irq_out
);

  // bus request and event carriers
  aecf_pkg::aecf_bus_req_t bus;
  aecf_pkg::aecf_events_t ev;

  // one sticky flag per stop cause
  logic cmp1_stop_flag_reg;
  logic cmp2_stop_flag_reg;
  logic cmp3_stop_flag_reg;
  logic pos_limit_stop_flag_reg;
  logic neg_limit_stop_flag_reg;
  logic alarm_stop_flag_reg;
  logic ext_stop_flag_reg;
  logic emergency_stop_flag_reg;
  logic slowdown_stop_flag_reg;
  logic pulser_overflow_flag_reg;
  logic comm_watchdog_stop_flag_reg;

  // next values of the flags
  logic cmp1_stop_flag_next;
  logic cmp2_stop_flag_next;
  logic cmp3_stop_flag_next;
  logic pos_limit_stop_flag_next;
  logic neg_limit_stop_flag_next;
  logic alarm_stop_flag_next;
  logic ext_stop_flag_next;
  logic emergency_stop_flag_next;
  logic slowdown_stop_flag_next;
  logic pulser_overflow_flag_next;
  logic comm_watchdog_stop_flag_next;

  // flags gathered into the cause word
  logic [aecf_pkg::CAUSE_W-1:0] cause_word;

  // control register
  logic status_read_clear_inhibit_reg;

  // interrupt registers, same layout as the cause word
  logic [aecf_pkg::CAUSE_W-1:0] irq_stat_reg;
  logic [aecf_pkg::CAUSE_W-1:0] irq_stat_next;
  logic [aecf_pkg::CAUSE_W-1:0] irq_en_reg;

  // read data register
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;

  // true when the bus address selects the given register
  function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] offset);
    return addr == offset;
  endfunction

  // sticky update, a raising event beats a clear in the same cycle
  function automatic logic flag_next(input logic cur, input logic clr, input logic set);
    return (cur & ~clr) | set;
  endfunction

  // gather the bus request
  assign bus = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};

  // gather the stop events, one field per cause
  assign ev = '{
    wdog_stop: comm_watchdog_stop_in,
    pulser_ovf: pulser_overflow_in,
    slowdown: slowdown_stop_in,
    emergency: emergency_stop_in,
    ext_stop: external_stop_in,
    alarm: servo_alarm_stop_in,
    neg_limit: neg_end_limit_stop_in,
    pos_limit: pos_end_limit_stop_in,
    cmp3: cmp3_stop_in,
    cmp2: cmp2_stop_in,
    cmp1: cmp1_stop_in
  };

  // address decode
  wire hit_cause = addr_hit(bus.addr, aecf_pkg::ADDR_CAUSE);
  wire hit_ctrl = addr_hit(bus.addr, aecf_pkg::ADDR_CTRL);
  wire hit_istat = addr_hit(bus.addr, aecf_pkg::ADDR_IRQ_STAT);
  wire hit_iclr = addr_hit(bus.addr, aecf_pkg::ADDR_IRQ_CLR);
  wire hit_ien = addr_hit(bus.addr, aecf_pkg::ADDR_IRQ_EN);

  // write strobes per register
  wire cause_wr = bus.wr && hit_cause;
  wire ctrl_wr = bus.wr && hit_ctrl;
  wire iclr_wr = bus.wr && hit_iclr;
  wire ien_wr = bus.wr && hit_ien;

  // read strobe of the cause word
  wire cause_rd = bus.rd && hit_cause;

  // write-one-to-clear mask, undefined bits of the write data are dropped
  wire [aecf_pkg::CAUSE_W-1:0] wr_clr = cause_wr ? bus.wdata[aecf_pkg::CAUSE_W-1:0] : '0;

  // an uninhibited read clears the whole word, so a retried read would lose flags
  wire rd_clr = cause_rd && !status_read_clear_inhibit_reg;
  wire [aecf_pkg::CAUSE_W-1:0] clr_mask = wr_clr | {aecf_pkg::CAUSE_W{rd_clr}};

  // next value of each flag
  assign cmp1_stop_flag_next = flag_next(cmp1_stop_flag_reg, clr_mask[aecf_pkg::BIT_CMP1], ev.cmp1);
  assign cmp2_stop_flag_next = flag_next(cmp2_stop_flag_reg, clr_mask[aecf_pkg::BIT_CMP2], ev.cmp2);
  assign cmp3_stop_flag_next = flag_next(cmp3_stop_flag_reg, clr_mask[aecf_pkg::BIT_CMP3], ev.cmp3);
  assign pos_limit_stop_flag_next = flag_next(pos_limit_stop_flag_reg, clr_mask[aecf_pkg::BIT_PEL], ev.pos_limit);
  assign neg_limit_stop_flag_next = flag_next(neg_limit_stop_flag_reg, clr_mask[aecf_pkg::BIT_NEL], ev.neg_limit);
  assign alarm_stop_flag_next = flag_next(alarm_stop_flag_reg, clr_mask[aecf_pkg::BIT_ALM], ev.alarm);
  assign ext_stop_flag_next = flag_next(ext_stop_flag_reg, clr_mask[aecf_pkg::BIT_STOP], ev.ext_stop);
  assign emergency_stop_flag_next = flag_next(emergency_stop_flag_reg, clr_mask[aecf_pkg::BIT_EMG], ev.emergency);
  assign slowdown_stop_flag_next = flag_next(slowdown_stop_flag_reg, clr_mask[aecf_pkg::BIT_SLOW], ev.slowdown);
  assign pulser_overflow_flag_next = flag_next(pulser_overflow_flag_reg, clr_mask[aecf_pkg::BIT_POVF], ev.pulser_ovf);
  assign comm_watchdog_stop_flag_next = flag_next(comm_watchdog_stop_flag_reg, clr_mask[aecf_pkg::BIT_WDOG],
    ev.wdog_stop);

  // flags gathered into the cause word, highest bit first
  assign cause_word = {
    comm_watchdog_stop_flag_reg,
    pulser_overflow_flag_reg,
    slowdown_stop_flag_reg,
    emergency_stop_flag_reg,
    ext_stop_flag_reg,
    alarm_stop_flag_reg,
    neg_limit_stop_flag_reg,
    pos_limit_stop_flag_reg,
    cmp3_stop_flag_reg,
    cmp2_stop_flag_reg,
    cmp1_stop_flag_reg
  };

  // any set flag raises the axis error request
  wire any_cause = |cause_word;

  // interrupt set and clear masks
  wire [aecf_pkg::CAUSE_W-1:0] set_mask = ev;
  wire [aecf_pkg::CAUSE_W-1:0] istat_clr = iclr_wr ? bus.wdata[aecf_pkg::CAUSE_W-1:0] : '0;

  // interrupt status, one sticky bit per cause, set beats clear
  always_comb begin
    irq_stat_next = irq_stat_reg;
    for (int i = 0; i < aecf_pkg::CAUSE_W; i++) begin
      irq_stat_next[i] = flag_next(irq_stat_reg[i], istat_clr[i], set_mask[i]);
    end
  end

  // read words, undefined and unused bits read as zero
  wire [31:0] cause_rd_word = {21'h0, cause_word};
  wire [31:0] ctrl_rd_word = {31'h0, status_read_clear_inhibit_reg};
  wire [31:0] istat_rd_word = {21'h0, irq_stat_reg};
  wire [31:0] ien_rd_word = {21'h0, irq_en_reg};

  // read mux, unmapped addresses read as zero
  assign rdata_next = !bus.rd ? 32'h0000_0000 :
    hit_cause ? cause_rd_word :
    hit_ctrl ? ctrl_rd_word :
    hit_istat ? istat_rd_word :
    hit_ien ? ien_rd_word : 32'h0000_0000;

  // comparator 1 stop flag
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cmp1_stop_flag_reg <= aecf_pkg::CAUSE_RST[aecf_pkg::BIT_CMP1];
    end else begin
      cmp1_stop_flag_reg <= cmp1_stop_flag_next;
    end
  end

  // comparator 2 stop flag
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cmp2_stop_flag_reg <= aecf_pkg::CAUSE_RST[aecf_pkg::BIT_CMP2];
    end else begin
      cmp2_stop_flag_reg <= cmp2_stop_flag_next;
    end
  end

  // comparator 3 stop flag
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cmp3_stop_flag_reg <= aecf_pkg::CAUSE_RST[aecf_pkg::BIT_CMP3];
    end else begin
      cmp3_stop_flag_reg <= cmp3_stop_flag_next;
    end
  end

  // positive end-limit stop flag
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pos_limit_stop_flag_reg <= aecf_pkg::CAUSE_RST[aecf_pkg::BIT_PEL];
    end else begin
      pos_limit_stop_flag_reg <= pos_limit_stop_flag_next;
    end
  end

  // negative end-limit stop flag
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      neg_limit_stop_flag_reg <= aecf_pkg::CAUSE_RST[aecf_pkg::BIT_NEL];
    end else begin
      neg_limit_stop_flag_reg <= neg_limit_stop_flag_next;
    end
  end

  // servo alarm stop flag
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      alarm_stop_flag_reg <= aecf_pkg::CAUSE_RST[aecf_pkg::BIT_ALM];
    end else begin
      alarm_stop_flag_reg <= alarm_stop_flag_next;
    end
  end

  // external stop flag
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ext_stop_flag_reg <= aecf_pkg::CAUSE_RST[aecf_pkg::BIT_STOP];
    end else begin
      ext_stop_flag_reg <= ext_stop_flag_next;
    end
  end

  // emergency stop flag
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      emergency_stop_flag_reg <= aecf_pkg::CAUSE_RST[aecf_pkg::BIT_EMG];
    end else begin
      emergency_stop_flag_reg <= emergency_stop_flag_next;
    end
  end

  // slow-down stop flag
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      slowdown_stop_flag_reg <= aecf_pkg::CAUSE_RST[aecf_pkg::BIT_SLOW];
    end else begin
      slowdown_stop_flag_reg <= slowdown_stop_flag_next;
    end
  end

  // manual pulser buffer overflow flag
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pulser_overflow_flag_reg <= aecf_pkg::CAUSE_RST[aecf_pkg::BIT_POVF];
    end else begin
      pulser_overflow_flag_reg <= pulser_overflow_flag_next;
    end
  end

  // communication watchdog stop flag
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      comm_watchdog_stop_flag_reg <= aecf_pkg::CAUSE_RST[aecf_pkg::BIT_WDOG];
    end else begin
      comm_watchdog_stop_flag_reg <= comm_watchdog_stop_flag_next;
    end
  end

  // read-clear inhibit control bit
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      status_read_clear_inhibit_reg <= aecf_pkg::CTRL_RCI_RST;
    end else begin
      if (ctrl_wr) begin
        status_read_clear_inhibit_reg <= bus.wdata[aecf_pkg::BIT_RCI];
      end
    end
  end

  // interrupt status bits
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      irq_stat_reg <= aecf_pkg::IRQ_STAT_RST;
    end else begin
      irq_stat_reg <= irq_stat_next;
    end
  end

  // interrupt enable bits
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      irq_en_reg <= aecf_pkg::IRQ_EN_RST;
    end else begin
      if (ien_wr) begin
        irq_en_reg <= bus.wdata[aecf_pkg::CAUSE_W-1:0];
      end
    end
  end

  // read data, valid the cycle after the strobe only
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rdata_reg <= aecf_pkg::RDATA_RST;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // read data output
  assign rdata_out = rdata_reg;

  // status and interrupt outputs
  assign axis_error_out = any_cause;
  assign irq_out = |(irq_stat_reg & irq_en_reg);

endmodule // aecf_cause_flags
`default_nettype wire

// *** verification/aecf_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module aecf_chk (
  // bus side
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic [31:0] rdata_out,
  // events and status
  input wire logic cmp1_stop_in,
  input wire logic cmp2_stop_in,
  input wire logic comm_watchdog_stop_in,
  input wire logic axis_error_out
);
  logic rci_reg;
  wire logic crd = rd_in && addr_in == 8'h00;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  // shadow of the read-clear inhibit bit
  always_ff @(posedge clk_in or negedge rstn_in)
    if (!rstn_in) rci_reg <= 1'b0;
    else if (wr_in && addr_in == 8'h04) rci_reg <= wdata_in[0];
  cmp1_set_a: assert property (cmp1_stop_in |=> axis_error_out) else $error("cmp1 lost");
  wdog_set_a: assert property (comm_watchdog_stop_in |=> axis_error_out) else $error("wdog lost");
  cmp2_read_a: assert property (cmp2_stop_in ##1 !wr_in && !rd_in ##1 crd |=> rdata_out[1]) else $error("cmp2");
  flag_hold_a: assert property (axis_error_out && !wr_in && !rd_in |=> axis_error_out) else $error("hold");
  rd_keep_a: assert property (crd && rci_reg && axis_error_out |=> axis_error_out) else $error("inhibit");
  rd_show_a: assert property (crd && axis_error_out |=> rdata_out[10:0] != 11'h0) else $error("show");
  top_zero_a: assert property ($past(rd_in) |-> rdata_out[31:11] == 21'h0) else $error("top bits");
  wr_keep_a: assert property (wr_in && addr_in == 8'h00 && wdata_in[10:0] == 11'h0 && axis_error_out
    |=> axis_error_out) else $error("zero write");
  cover property (crd && rci_reg && axis_error_out);
  cover property (crd && !rci_reg && axis_error_out);
  cover property (wr_in && addr_in == 8'h00 && axis_error_out);
endmodule // aecf_chk
bind aecf_cause_flags aecf_chk chk (.*);
`default_nettype wire

// *** verification/aecf_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module aecf_host (
  input wire logic clk_in,
  input wire logic [31:0] rdata_in,
  output logic [7:0] addr_out,
  output logic [31:0] wdata_out,
  output logic wr_out,
  output logic rd_out
);
  initial {addr_out, wdata_out, wr_out, rd_out} = '0;
  // one strobe cycle, then address and data released to inverted values and both strobes dropped
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_in);
    {addr_out, wdata_out, wr_out, rd_out} <= {a, d, w, !w};
    @(posedge clk_in);
    {addr_out, wdata_out, wr_out, rd_out} <= {~a, ~d, 2'b00};
    #1 q = rdata_in;
  endtask
endmodule // aecf_host
`default_nettype wire

// *** verification/tb_axis_error_stop_cause_flags.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_axis_error_stop_cause_flags;
  logic clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic [10:0] ev = '0;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, q;
  logic wr, rd, aerr, irq;
  int err_total = 0;
  int n_checks = 0;
  int cyc = 0;
  always #50 clk_in = ~clk_in;
  aecf_host host (.clk_in, .rdata_in(rdata), .addr_out(addr), .wdata_out(wdata), .wr_out(wr), .rd_out(rd));
  aecf_cause_flags uut (.clk_in, .rstn_in, .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
    .cmp1_stop_in(ev[0]), .cmp2_stop_in(ev[1]), .cmp3_stop_in(ev[2]), .pos_end_limit_stop_in(ev[3]),
    .neg_end_limit_stop_in(ev[4]), .servo_alarm_stop_in(ev[5]), .external_stop_in(ev[6]), .emergency_stop_in(ev[7]),
    .slowdown_stop_in(ev[8]), .pulser_overflow_in(ev[9]), .comm_watchdog_stop_in(ev[10]), .axis_error_out(aerr),
    .irq_out(irq));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic conclude;
    if (err_total == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
    host.xfer(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, q);
  endtask
  // cause rows: event mask beside the cause word it should give
  typedef struct packed {
    logic [10:0] ev;
    logic [31:0] want;
  } aecf_row_t;
  aecf_row_t rows [12] = '{'{11'h001, 32'h001}, '{11'h002, 32'h002}, '{11'h004, 32'h004}, '{11'h008, 32'h008},
    '{11'h010, 32'h010}, '{11'h020, 32'h020}, '{11'h040, 32'h040}, '{11'h080, 32'h080},
    '{11'h100, 32'h100}, '{11'h200, 32'h200}, '{11'h400, 32'h400}, '{11'h401, 32'h401}};
  // one-cycle event pulse
  task automatic fire(input logic [10:0] m);
    @(posedge clk_in) ev <= m;
    @(posedge clk_in) ev <= '0;
  endtask
  // cut a hang short
  always @(posedge clk_in) begin
    cyc++;
    if (cyc > 2000) begin
      err_total++;
      conclude;
    end
  end
  // cause rows, then inhibit, clearing, interrupt and reset cases
  initial begin
    repeat (16) @(posedge clk_in);
    rstn_in <= 1'b1;
    foreach (rows[i]) begin
      fire(rows[i].ev);
      rd_reg(8'h00, rows[i].want);
      rd_reg(8'h00, 32'h0);
    end
    chk(32'(aerr), 32'h0);
    chk(32'(irq), 32'h0);
    wr_reg(8'h04, 32'h1);
    fire(11'h018);
    rd_reg(8'h00, 32'h18);
    wr_reg(8'h00, 32'hfffff800);
    rd_reg(8'h00, 32'h18);
    wr_reg(8'h00, 32'h10);
    rd_reg(8'h00, 32'h08);
    chk(32'(aerr), 32'h1);
    wr_reg(8'h00, 32'h08);
    chk(32'(aerr), 32'h0);
    wr_reg(8'h10, 32'h1);
    chk(32'(irq), 32'h1);
    wr_reg(8'h0c, 32'h1);
    chk(32'(irq), 32'h0);
    fire(11'h400);
    #1 chk(32'(aerr), 32'h1);
    @(posedge clk_in) rstn_in <= 1'b0;
    #1 chk(32'(aerr), 32'h0);
    repeat (2) @(posedge clk_in);
    rstn_in <= 1'b1;
    for (int a = 0; a < 24; a += 4) rd_reg(8'(a), 32'h0);
    conclude;
  end
endmodule // tb_axis_error_stop_cause_flags
`default_nettype wire
